// file: design/cbx_regs.vh
`ifndef CBX_REGS_VH
`define CBX_REGS_VH
// opcode fields of the 16-bit instruction word
`define CBX_OPC_HI 15
`define CBX_OPC_LO 11
`define CBX_OPC_SHIFT 5'h01
`define CBX_OPC_BRANCH_LO 5'h04
`define CBX_OPC_BRANCH_MI 5'h05
`define CBX_BR_SEL_BIT 9
`define CBX_BR_SEL_COND 1'h1
`define CBX_BREAK_WORD 16'h0000
`define CBX_RD_HI 10
`define CBX_RD_LO 8
`define CBX_RS_HI 7
`define CBX_RS_LO 5
`define CBX_IMM_HI 7
`define CBX_IMM_LO 4
`define CBX_SUB_HI 3
`define CBX_SUB_LO 0
`define CBX_SUB_IMM 4'hC
`define CBX_SUB_REG 4'h4
`define CBX_DYA_MARK_BIT 4
`define CBX_DYA_MARK 1'h1
`define CBX_OFS_HI 8
`define CBX_OFS_LO 0
// pc step and shift limits
`define CBX_PC_STEP 16'h0002
`define CBX_SHIFT_MAX 5'h10
`define CBX_SRC_LIMIT 16'h000F
`define CBX_IMM_ZERO 4'h0
// pc and flag reset values
`define CBX_PC_RESET 16'h0000
`define CBX_FLAGS_RESET 4'h0
`endif

// file: design/cbx_shifter.v
`timescale 1ns/1ns
`include "cbx_regs.vh"
// logical shift left with flag results
module cbx_shifter #(
	parameter WIDTH = 16
) (
	input wire [WIDTH-1:0] operand,
	input wire [4:0] count,
	input wire carry_in,
	output reg [WIDTH-1:0] result,
	output reg neg,
	output reg zero,
	output reg ovf,
	output reg carry
);
	reg [2*WIDTH-1:0] wide;
	// widened shift so bit 16-n falls into the upper half
	always @* begin
		wide = {{WIDTH{1'b0}}, operand} << count;
		result = wide[WIDTH-1:0];
		neg = result[WIDTH-1];
		zero = (result == {WIDTH{1'b0}});
		ovf = operand[WIDTH-1] ^ result[WIDTH-1];
		carry = (count == 5'h00) ? carry_in : wide[WIDTH];
	end
endmodule // cbx_shifter

// file: design/cbx_exec.v
`timescale 1ns/1ns
`include "cbx_regs.vh"
module cbx_exec (
	input wire mclk,
	input wire rstn,
	input wire instr_valid,
	input wire [15:0] instr,
	input wire debug_exit,
	input wire single_step,
	output reg [15:0] pc_q,
	output reg flag_n_q,
	output reg flag_z_q,
	output reg flag_v_q,
	output reg flag_c_q,
	output reg debug_mode_q,
	output reg sw_breakpoint_q,
	output reg reg_we_q,
	output reg [2:0] reg_waddr_q,
	output reg [15:0] reg_wdata_q,
	output reg [2:0] reg_raddr_d_q,
	output reg [2:0] reg_raddr_s_q,
	input wire [15:0] reg_rdata_d,
	input wire [15:0] reg_rdata_s
);
	localparam ST_DECODE = 2'b00;
	localparam ST_SHIFT = 2'b01;
	localparam ST_DEBUG = 2'b10;

	reg [1:0] state_q;
	reg [1:0] state_d;
	reg [15:0] instr_q;
	reg [4:0] count;
	wire [15:0] sh_result;
	wire sh_n;
	wire sh_z;
	wire sh_v;
	wire sh_c;
	wire [4:0] opc;
	wire [15:0] rel_ofs;
	wire [15:0] br_target;
	wire is_break;
	wire is_blo;
	wire is_bmi;
	wire is_shift;
	wire may_run;

	assign opc = instr[`CBX_OPC_HI:`CBX_OPC_LO];
	// offset sign-extended and doubled
	assign rel_ofs = {{6{instr[`CBX_OFS_HI]}}, instr[`CBX_OFS_HI:`CBX_OFS_LO], 1'b0};
	assign br_target = pc_q + `CBX_PC_STEP + rel_ofs;
	assign is_break = (instr == `CBX_BREAK_WORD);
	assign is_blo = (opc == `CBX_OPC_BRANCH_LO) && (instr[`CBX_BR_SEL_BIT] == `CBX_BR_SEL_COND);
	assign is_bmi = (opc == `CBX_OPC_BRANCH_MI) && (instr[`CBX_BR_SEL_BIT] == `CBX_BR_SEL_COND);
	assign is_shift = (opc == `CBX_OPC_SHIFT) &&
		((instr[`CBX_SUB_HI:`CBX_SUB_LO] == `CBX_SUB_IMM) ||
		((instr[`CBX_SUB_HI:`CBX_SUB_LO] == `CBX_SUB_REG) && (instr[`CBX_DYA_MARK_BIT] == `CBX_DYA_MARK)));
	// a step request runs one instruction and stays halted, except a stepped shift, which returns to run state
	assign may_run = instr_valid && (state_q == ST_DECODE);

	// shift count selection, register operands read a cycle after decode
	always @* begin
		if (instr_q[`CBX_SUB_HI:`CBX_SUB_LO] == `CBX_SUB_IMM) begin
			if (instr_q[`CBX_IMM_HI:`CBX_IMM_LO] == `CBX_IMM_ZERO)
				count = `CBX_SHIFT_MAX;
			else
				count = {1'b0, instr_q[`CBX_IMM_HI:`CBX_IMM_LO]};
		end else begin
			if (reg_rdata_s > `CBX_SRC_LIMIT)
				count = `CBX_SHIFT_MAX;
			else
				count = reg_rdata_s[4:0];
		end
	end

	cbx_shifter #(
		.WIDTH(16)
	) u_shift (
		.operand(reg_rdata_d),
		.count(count),
		.carry_in(flag_c_q),
		.result(sh_result),
		.neg(sh_n),
		.zero(sh_z),
		.ovf(sh_v),
		.carry(sh_c)
	);

	// next state
	always @* begin
		state_d = state_q;
		case (state_q)
		ST_DECODE: begin
			if (instr_valid && is_break)
				state_d = ST_DEBUG;
			else if (instr_valid && is_shift)
				state_d = ST_SHIFT;
		end
		ST_SHIFT: begin
			state_d = ST_DECODE;
		end
		ST_DEBUG: begin
			// stepping a break re-executes it and stays halted
			if (debug_exit && !is_break)
				state_d = ST_DECODE;
			else if (single_step && instr_valid && is_shift && !is_break)
				state_d = ST_SHIFT;
		end
		default: begin
			state_d = ST_DECODE;
		end
		endcase
	end

	// core sequencing; untaken paths only step pc
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			state_q <= ST_DECODE;
			instr_q <= 16'h0000;
			pc_q <= `CBX_PC_RESET;
			{flag_n_q, flag_z_q, flag_v_q, flag_c_q} <= `CBX_FLAGS_RESET;
			debug_mode_q <= 1'b0;
			sw_breakpoint_q <= 1'b0;
			reg_we_q <= 1'b0;
			reg_waddr_q <= 3'h0;
			reg_wdata_q <= 16'h0000;
			reg_raddr_d_q <= 3'h0;
			reg_raddr_s_q <= 3'h0;
		end else begin
			state_q <= state_d;
			sw_breakpoint_q <= 1'b0;
			reg_we_q <= 1'b0;
			debug_mode_q <= (state_d == ST_DEBUG);
			if (may_run || (state_q == ST_DEBUG && single_step && instr_valid)) begin
				instr_q <= instr;
				reg_raddr_d_q <= instr[`CBX_RD_HI:`CBX_RD_LO];
				reg_raddr_s_q <= instr[`CBX_RS_HI:`CBX_RS_LO];
				if (is_break) begin
					sw_breakpoint_q <= 1'b1;
					pc_q <= pc_q;
				end else if (is_blo) begin
					pc_q <= flag_c_q ? br_target : pc_q + `CBX_PC_STEP;
				end else if (is_bmi) begin
					pc_q <= flag_n_q ? br_target : pc_q + `CBX_PC_STEP;
				end else if (!is_shift) begin
					pc_q <= pc_q + `CBX_PC_STEP;
				end
			end
			if (state_q == ST_SHIFT) begin
				reg_we_q <= 1'b1;
				reg_waddr_q <= reg_raddr_d_q;
				reg_wdata_q <= sh_result;
				flag_n_q <= sh_n;
				flag_z_q <= sh_z;
				flag_v_q <= sh_v;
				flag_c_q <= sh_c;
				pc_q <= pc_q + `CBX_PC_STEP;
			end
		end
	end
endmodule // cbx_exec

// file: test/cbx_exec_monitor.sv
`timescale 1ns/1ns
module cbx_exec_chk (
	input wire mclk,
	input wire rstn,
	input wire instr_valid,
	input wire [15:0] instr,
	input wire [15:0] pc_q,
	input wire flag_n_q,
	input wire flag_z_q,
	input wire flag_v_q,
	input wire flag_c_q,
	input wire debug_mode_q,
	input wire sw_breakpoint_q,
	input wire reg_we_q,
	input wire [15:0] reg_wdata_q,
	input wire [15:0] reg_rdata_d
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	// words accepted in run state; words stepped in while in debug state are not covered
	sequence s_brk;
		instr_valid && !debug_mode_q && instr == 16'h0000;
	endsequence
	sequence s_mi;
		instr_valid && !debug_mode_q && instr[15:9] == 7'h15 && flag_n_q;
	endsequence
	a_brk_halts: assert property (s_brk |=> debug_mode_q && sw_breakpoint_q)
		else $error("no halt");
	a_brk_pc_hold: assert property (sw_breakpoint_q |-> $stable(pc_q))
		else $error("pc moved");
	a_brk_flags: assert property (sw_breakpoint_q |-> $stable({flag_n_q, flag_z_q, flag_v_q, flag_c_q}))
		else $error("flags moved");
	a_mi_target: assert property (s_mi |=> pc_q == $past(pc_q) + 16'h0002 +
		{{6{$past(instr[8])}}, $past(instr[8:0]), 1'b0}) else $error("bad target");
	a_we_single: assert property (reg_we_q |=> !reg_we_q)
		else $error("long write");
	a_shift_neg: assert property (reg_we_q |-> flag_n_q == reg_wdata_q[15])
		else $error("bad n");
	a_shift_zero: assert property (reg_we_q |-> flag_z_q == (reg_wdata_q == 16'h0000))
		else $error("bad z");
	a_shift_ovf: assert property (reg_we_q |-> flag_v_q == ($past(reg_rdata_d[15]) ^ reg_wdata_q[15]))
		else $error("bad v");
endmodule // cbx_exec_chk
bind cbx_exec cbx_exec_chk u_chk (.*);

// file: test/testbench.sv
`timescale 1ns/1ns
module testbench;
	logic mclk = 1'b0, rstn = 1'b0, instr_valid = 1'b0, debug_exit = 1'b0, single_step = 1'b0;
	logic [15:0] instr = 16'h0000, xpc = 16'h0000;
	logic [15:0] rf [8];
	int err_count = 0, n_checks = 0;
	wire [15:0] pc_q, reg_wdata_q;
	wire flag_n_q, flag_z_q, flag_v_q, flag_c_q, debug_mode_q, sw_breakpoint_q, reg_we_q;
	wire [2:0] reg_waddr_q, reg_raddr_d_q, reg_raddr_s_q;
	wire [15:0] reg_rdata_d = rf[reg_raddr_d_q];
	wire [15:0] reg_rdata_s = rf[reg_raddr_s_q];
	wire [15:0] flags = {12'h000, flag_n_q, flag_z_q, flag_v_q, flag_c_q};
	cbx_exec u_dut (.*);
	initial forever #10 mclk = ~mclk;
	// hang guard
	initial begin
		#100000;
		err_count++;
		test_done();
	end
	task chk(input logic [15:0] g, input logic [15:0] e);
		n_checks++;
		if (g !== e) begin
			err_count++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask
	task test_done;
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// word held k edges; a shift needs two
	task run(input logic [15:0] w, input int k);
		@(posedge mclk) begin
			instr <= w;
			instr_valid <= 1'b1;
		end
		repeat (k) @(posedge mclk);
		instr_valid <= 1'b0;
		@(negedge mclk);
	endtask
	task br(input logic mi, input logic [8:0] ofs);
		logic [15:0] f;
		f = flags;
		xpc = xpc + 16'h0002 + (((mi ? flag_n_q : flag_c_q) === 1'b1) ? {{6{ofs[8]}}, ofs, 1'b0} : 16'h0000);
		run({4'h2, mi, 2'h1, ofs}, 1);
		chk(pc_q, xpc);
		chk(flags, f);
		$display("branch done");
	endtask
	// count source sits in r7, so d must differ
	task sh(input logic two_register_form, input logic [2:0] d, input logic [15:0] dv, input logic [15:0] cv);
		int k;
		logic [15:0] r;
		logic cy;
		rf[d] = dv;
		rf[7] = cv;
		k = two_register_form ? (cv > 15 ? 16 : cv) : (cv[3:0] == 0 ? 16 : cv[3:0]);
		r = (k == 16) ? 16'h0000 : dv << k;
		cy = (k == 0) ? flag_c_q : dv[16 - k];
		xpc = xpc + 16'h0002;
		run(two_register_form ? {5'h01, d, 3'h7, 5'h14} : {5'h01, d, cv[3:0], 4'hC}, 2);
		chk({12'h000, reg_we_q, reg_waddr_q}, {13'h0001, d});
		chk(reg_wdata_q, r);
		chk(flags, {12'h000, r[15], r == 16'h0000, dv[15] ^ r[15], cy});
		chk(pc_q, xpc);
		$display("shift done");
	endtask
	task software_break_instr;
		logic [15:0] f;
		f = flags;
		run(16'h0000, 1);
		chk({14'h0000, debug_mode_q, sw_breakpoint_q}, 16'h0003);
		chk({pc_q, flags}, {xpc, f});
		@(posedge mclk) begin
			single_step <= 1'b1;
			instr_valid <= 1'b1;
		end
		@(posedge mclk) begin
			single_step <= 1'b0;
			instr_valid <= 1'b0;
		end
		@(negedge mclk) chk({pc_q[13:0], debug_mode_q, sw_breakpoint_q}, {xpc[13:0], 2'h3});
		@(posedge mclk) begin
			instr <= 16'h0800;
			debug_exit <= 1'b1;
		end
		@(posedge mclk) debug_exit <= 1'b0;
		@(negedge mclk) chk({15'h0000, debug_mode_q}, 16'h0000);
		$display("break done");
	endtask
	initial begin
		repeat (4) @(posedge mclk);
		rstn <= 1'b1;
		br(1'b0, 9'h010);
		sh(1'b0, 3'h1, 16'h0001, 16'h0000);
		br(1'b0, 9'h1FE);
		sh(1'b1, 3'h2, 16'h0001, 16'h000F);
		br(1'b1, 9'h010);
		sh(1'b1, 3'h4, 16'h8003, 16'h0011);
		sh(1'b1, 3'h6, 16'h4001, 16'h0000);
		sh(1'b0, 3'h5, 16'hA5A5, 16'h0003);
		br(1'b1, 9'h0F0);
		software_break_instr();
		test_done();
	end
endmodule // testbench
